// file: rtl/host_bus_strap_and_strobe.sv
// Host bus strap and strobe front end: strap sampling, direction, qualifier,
// address latch and power-down input of the generic host port.
// Assumes all host pins are asynchronous and pass two flops before use.
//
// Summary of operation
// - With memory, data pin carries memory data
// - No memory, 32-bit strap low: data pin low 8, high 16
// - Direction high means write, low read
// - Decode only while qualifier is low
// - Latch address and qualifier on strobe rise
// - Sleep while power-down input is low
`timescale 1ns/1ps
`include "host_bus_strap_params.svh"
module host_bus_strap_and_strobe (
    input  wire logic                   core_clk,
    input  wire logic                   nrst,
    input  wire logic                   cfg_mem_present_strap,
    input  wire logic                   cfg_mem_data_in,
    input  wire logic                   bus32_strap,
    input  wire logic                   sync_write_not_read,
    input  wire logic                   addr_qualifier_n,
    input  wire logic                   addr_latch_strobe_n,
    input  wire logic [`HBS_ADDR_W-1:0] host_addr,
    input  wire logic                   chip_sleep_n,
    output logic      [1:0]             bus_width,
    output logic                        width_valid,
    output logic                        cfg_mem_bit,
    output logic                        cfg_mem_bit_valid,
    output logic      [`HBS_ADDR_W-1:0] latched_addr,
    output logic                        latched_qualifier_n,
    output logic                        latch_pulse,
    output logic                        decode_enable,
    output logic                        access_is_write,
    output logic                        chip_asleep
);
    // Width of the synchronised pin bundle: five single pins, two straps, address
    localparam int SYNC_W = `HBS_ADDR_W + 7;
    // Counter end value; settle spans HBS_SETTLE_CYC clocks after reset
    localparam logic [`HBS_SETTLE_CNT_W-1:0] SETTLE_LAST =
        `HBS_SETTLE_CNT_W'(`HBS_SETTLE_CYC - 1);

    // All module state in one struct
    typedef struct packed {
        host_bus_strap_pkg::phase_e     phase;
        logic [`HBS_SETTLE_CNT_W-1:0]   settle_cnt;
        logic                           mem_present;
        host_bus_strap_pkg::bus_width_e width;
        logic                           width_valid;
        logic                           mem_bit;
        logic                           mem_bit_valid;
        logic                           strobe_n_d;
        host_bus_strap_pkg::latch_s     latch;
        logic                           latch_pulse;
        logic                           decode_en;
        logic                           is_write;
        logic                           asleep;
    } top_state_s;

    top_state_s                  state_reg;   // Registered state
    top_state_s                  state_next;  // Next state
    logic [SYNC_W-1:0]           sync_vec;    // Synchronised pin bundle
    logic                        mem_strap_s; // Synchronised memory strap
    logic                        bus32_s;     // Synchronised 32-bit strap
    host_bus_strap_pkg::pins_s   pins;        // Synchronised host pins

    // Every pin is asynchronous, so all go through the shared synchroniser
    // One shared synchroniser costs two clocks of latency on every pin;
    // the host must hold each level at least one clock for it to be seen
    pin_sync2 #(.W(SYNC_W)) u_sync (
        .core_clk (core_clk),
        .nrst     (nrst),
        .async_in ({cfg_mem_present_strap, bus32_strap, sync_write_not_read,
                    addr_qualifier_n, addr_latch_strobe_n, host_addr,
                    chip_sleep_n, cfg_mem_data_in}),
        .sync_out (sync_vec)
    );

    assign mem_strap_s = sync_vec[SYNC_W-1];
    assign bus32_s     = sync_vec[SYNC_W-2];
    assign pins        = host_bus_strap_pkg::pins_s'(sync_vec[SYNC_W-3:0]);

    // Width decode from the data pin level and the 32-bit strap
    function automatic host_bus_strap_pkg::bus_width_e pick_width(
        input logic is32,
        input logic data_level
    );
        if (is32) begin
            pick_width = host_bus_strap_pkg::BUS_W32;   // Data level ignored
        end else if (data_level) begin
            pick_width = host_bus_strap_pkg::BUS_W16;
        end else begin
            pick_width = host_bus_strap_pkg::BUS_W8;
        end
    endfunction : pick_width

    // Next-state logic
    always_comb begin
        state_next             = state_reg;
        state_next.latch_pulse = 1'b0;
        state_next.strobe_n_d  = pins.strobe_n;
        case (state_reg.phase)
            host_bus_strap_pkg::ST_SETTLE: begin
                // Wait for the synchroniser and strap pins to settle
                if (state_reg.settle_cnt == SETTLE_LAST) begin
                    // The board owns the strap level; we only sample it
                    state_next.mem_present = mem_strap_s;
                    state_next.width       = pick_width(bus32_s, pins.cfg_data);
                    state_next.width_valid = 1'b1;
                    state_next.phase       = host_bus_strap_pkg::ST_RUN;
                end else begin
                    state_next.settle_cnt = state_reg.settle_cnt + `HBS_SETTLE_CNT_W'(1);
                end
            end
            host_bus_strap_pkg::ST_RUN, host_bus_strap_pkg::ST_SLEEP: begin
                // Memory data path is live only when memory is fitted
                state_next.mem_bit       = state_reg.mem_present & pins.cfg_data;
                state_next.mem_bit_valid = state_reg.mem_present;
                state_next.is_write      = pins.write_not_read;
                // Rising strobe edge captures address and qualifier
                if (pins.strobe_n && !state_reg.strobe_n_d) begin
                    state_next.latch.addr        = pins.addr;
                    state_next.latch.qualifier_n = pins.qualifier_n;
                    state_next.latch_pulse       = 1'b1;
                end
                // Decoding stays off while asleep or while qualifier is high
                state_next.decode_en = !pins.qualifier_n && pins.sleep_n;
                state_next.asleep    = !pins.sleep_n;
                state_next.phase     = pins.sleep_n ? host_bus_strap_pkg::ST_RUN
                                                    : host_bus_strap_pkg::ST_SLEEP;
            end
            default: begin
                state_next.phase = host_bus_strap_pkg::ST_SETTLE;
            end
        endcase
    end

    // State register; strobe history resets high to avoid a false edge
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state_reg                   <= '0;
            state_reg.phase             <= host_bus_strap_pkg::ST_SETTLE;
            state_reg.strobe_n_d        <= 1'b1;
            state_reg.latch.qualifier_n <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from state flops
    assign bus_width           = state_reg.width;
    assign width_valid         = state_reg.width_valid;
    assign cfg_mem_bit         = state_reg.mem_bit;
    assign cfg_mem_bit_valid   = state_reg.mem_bit_valid;
    assign latched_addr        = state_reg.latch.addr;
    assign latched_qualifier_n = state_reg.latch.qualifier_n;
    assign latch_pulse         = state_reg.latch_pulse;
    assign decode_enable       = state_reg.decode_en;
    assign access_is_write     = state_reg.is_write;
    assign chip_asleep         = state_reg.asleep;

    // Strap capture checks: the width is taken once, at the end of settle
    AST_WIDTH_16: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_reg.phase == host_bus_strap_pkg::ST_SETTLE && state_next.width_valid
         && !bus32_s && pins.cfg_data) |=> bus_width == `HBS_WIDTH_16)
        else $error("width not 16 with data high");
    AST_WIDTH_8: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_reg.phase == host_bus_strap_pkg::ST_SETTLE && state_next.width_valid
         && !bus32_s && !pins.cfg_data) |=> bus_width == `HBS_WIDTH_8)
        else $error("width not 8 with data low");
    // A high 32-bit strap wins whatever the data pin shows
    AST_WIDTH_32: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_reg.phase == host_bus_strap_pkg::ST_SETTLE && state_next.width_valid
         && bus32_s) |=> bus_width == `HBS_WIDTH_32)
        else $error("width not 32 with 32-bit strap high");
    // The rest of the host port assumes the width never moves once valid
    AST_WIDTH_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
        width_valid |=> $stable(bus_width) && width_valid)
        else $error("strap width changed after capture");
    // Memory data path checks
    AST_MEM_BIT: assert property (@(posedge core_clk) disable iff (!nrst)
        cfg_mem_bit |-> cfg_mem_bit_valid)
        else $error("memory bit without memory fitted");
    // Bit follows the data pin one clock later, and stays low with no memory
    AST_MEM_DATA: assert property (@(posedge core_clk) disable iff (!nrst)
        (width_valid && $past(width_valid))
        |-> cfg_mem_bit == (cfg_mem_bit_valid && $past(pins.cfg_data)))
        else $error("memory bit not following data pin");
    // Host direction and qualifier checks
    AST_DIR: assert property (@(posedge core_clk) disable iff (!nrst)
        (width_valid && $past(width_valid)) |-> access_is_write == $past(pins.write_not_read))
        else $error("direction not following pin");
    AST_DECODE: assert property (@(posedge core_clk) disable iff (!nrst)
        decode_enable |-> !$past(pins.qualifier_n))
        else $error("decode while qualifier high");
    // Address latch checks
    AST_LATCH: assert property (@(posedge core_clk) disable iff (!nrst)
        (width_valid && pins.strobe_n && !state_reg.strobe_n_d)
        |=> latch_pulse && latched_addr == $past(pins.addr))
        else $error("address not latched on strobe rise");
    AST_LATCH_QUAL: assert property (@(posedge core_clk) disable iff (!nrst)
        (width_valid && pins.strobe_n && !state_reg.strobe_n_d)
        |=> latched_qualifier_n == $past(pins.qualifier_n))
        else $error("qualifier not latched on strobe rise");
    AST_LATCH_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
        !latch_pulse |-> $stable(latched_addr))
        else $error("latched address moved without strobe");
    // Nothing may be latched before the straps have settled
    AST_NO_EARLY_LATCH: assert property (@(posedge core_clk) disable iff (!nrst)
        !width_valid |=> !latch_pulse)
        else $error("address latched before settle ended");
    // Power-down checks
    AST_SLEEP: assert property (@(posedge core_clk) disable iff (!nrst)
        (width_valid && !pins.sleep_n) |=> chip_asleep && !decode_enable)
        else $error("not asleep with power-down low");
    AST_WAKE: assert property (@(posedge core_clk) disable iff (!nrst)
        (width_valid && pins.sleep_n) |=> !chip_asleep)
        else $error("asleep with power-down input high");
    // Coverage of the main scenarios
    COV_W16: cover property (@(posedge core_clk) disable iff (!nrst)
        width_valid && bus_width == `HBS_WIDTH_16);
    COV_LATCH: cover property (@(posedge core_clk) disable iff (!nrst) latch_pulse);
    COV_SLEEP_WAKE: cover property (@(posedge core_clk) disable iff (!nrst)
        chip_asleep ##1 !chip_asleep);
    COV_WRITE: cover property (@(posedge core_clk) disable iff (!nrst)
        decode_enable && access_is_write);
endmodule : host_bus_strap_and_strobe

// file: rtl/host_bus_strap_params.svh
// Constants for the host bus strap and strobe front end.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef HOST_BUS_STRAP_PARAMS_SVH
`define HOST_BUS_STRAP_PARAMS_SVH
`define HBS_ADDR_MSB        15
`define HBS_ADDR_LSB        1
`define HBS_ADDR_W          15
`define HBS_WIDTH_8         2'h0
`define HBS_WIDTH_16        2'h1
`define HBS_WIDTH_32        2'h2
`define HBS_SETTLE_NS       200
`define HBS_CLK_PERIOD_NS   40
`define HBS_SETTLE_CYC      ((`HBS_SETTLE_NS + `HBS_CLK_PERIOD_NS - 1) / `HBS_CLK_PERIOD_NS)
`define HBS_SETTLE_CNT_W    3
`endif

// file: rtl/host_bus_strap_pkg.sv
// Types shared by the host bus strap and strobe front end.
// Assumes the params header sits in the include path.
`include "host_bus_strap_params.svh"
package host_bus_strap_pkg;
    typedef enum logic [1:0] {
        BUS_W8  = 2'h0,
        BUS_W16 = 2'h1,
        BUS_W32 = 2'h2
    } bus_width_e;

    typedef enum logic [1:0] {
        ST_SETTLE = 2'h0,   // Waiting for strap levels to settle
        ST_RUN    = 2'h1,   // Strap captured, bus live
        ST_SLEEP  = 2'h2    // Full-chip power-down
    } phase_e;

    // Host pin group after synchronisation
    typedef struct packed {
        logic                      write_not_read;
        logic                      qualifier_n;
        logic                      strobe_n;
        logic [`HBS_ADDR_W-1:0]    addr;
        logic                      sleep_n;
        logic                      cfg_data;
    } pins_s;

    // Address latch result handed to the rest of the host interface
    typedef struct packed {
        logic [`HBS_ADDR_W-1:0]    addr;
        logic                      qualifier_n;
    } latch_s;
endpackage : host_bus_strap_pkg

// file: rtl/pin_sync2.sv
// Two-stage synchroniser for a vector of host pins.
// Assumes pins are asynchronous to core_clk; the first stage feeds only the second.
`timescale 1ns/1ps
module pin_sync2 #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_state_s;

    sync_state_s state_reg;   // Both stages
    sync_state_s state_next;  // Next value

    // Shift the pin through two flops
    always_comb begin
        state_next.meta   = async_in;
        state_next.stable = state_reg.meta;
    end

    // Reset to zero; reads are only trusted once the top block leaves settle
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.stable;
endmodule : pin_sync2

// file: verification/host_bus_strap_and_strobe_tb_top.sv
// Self-checking bench for the host bus strap and strobe front end.
// Assumes 3-edge pin latency and width_valid at the 5th edge after reset.
`timescale 1ns/1ps
`include "host_bus_strap_params.svh"
module host_bus_strap_and_strobe_tb_top;
    typedef struct packed {
        logic       mem;
        logic       data;
        logic       b32;
        logic [1:0] width;
        logic       chkw;   // Width is not defined while memory is fitted
    } row_s;
    logic core_clk, nrst, mem_s, data_s, b32_s, wr_s, q_s, stb_s, slp_s;
    logic [`HBS_ADDR_W-1:0] addr_s, l_addr;
    logic [1:0] bus_width;
    logic width_valid, mem_bit, mem_bit_valid, l_q, pulse, dec_en, is_wr, asleep;
    int bad_count = 0;
    int checked = 0;
    row_s rows[5] = '{'{1'b0, 1'b0, 1'b0, host_bus_strap_pkg::BUS_W8, 1'b1},
                      '{1'b0, 1'b1, 1'b0, host_bus_strap_pkg::BUS_W16, 1'b1},
                      '{1'b0, 1'b0, 1'b1, host_bus_strap_pkg::BUS_W32, 1'b1},
                      '{1'b0, 1'b1, 1'b1, host_bus_strap_pkg::BUS_W32, 1'b1},
                      '{1'b1, 1'b1, 1'b0, host_bus_strap_pkg::BUS_W8, 1'b0}};

    host_pin_model i_host_pin_model (.core_clk(core_clk), .cfg_mem_present_strap(mem_s),
        .cfg_mem_data_in(data_s), .bus32_strap(b32_s), .sync_write_not_read(wr_s),
        .addr_qualifier_n(q_s), .addr_latch_strobe_n(stb_s), .host_addr(addr_s),
        .chip_sleep_n(slp_s));
    host_bus_strap_and_strobe i_host_bus_strap_and_strobe (.core_clk(core_clk), .nrst(nrst),
        .cfg_mem_present_strap(mem_s), .cfg_mem_data_in(data_s), .bus32_strap(b32_s),
        .sync_write_not_read(wr_s), .addr_qualifier_n(q_s), .addr_latch_strobe_n(stb_s),
        .host_addr(addr_s), .chip_sleep_n(slp_s), .bus_width(bus_width),
        .width_valid(width_valid), .cfg_mem_bit(mem_bit), .cfg_mem_bit_valid(mem_bit_valid),
        .latched_addr(l_addr), .latched_qualifier_n(l_q), .latch_pulse(pulse),
        .decode_enable(dec_en), .access_is_write(is_wr), .chip_asleep(asleep));

    // 25 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic give_verdict();
        if (bad_count == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict

    task automatic cmp_bit(input string name, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask : cmp_bit

    task automatic cmp_vec(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp_vec

    // Let n edges pass, then sample once their updates have landed
    task automatic edges(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : edges

    // Six-cycle reset with straps applied, reset values checked at its end
    task automatic do_reset(input row_s r);
        nrst = 1'b0;
        i_host_pin_model.set_straps(r.mem, r.data, r.b32);
        edges(6);
        cmp_vec("rst_width", 16'h0000, {14'h0000, bus_width});
        cmp_bit("rst_valid", 1'b0, width_valid);
        cmp_bit("rst_qual", 1'b1, l_q);
        cmp_bit("rst_decode", 1'b0, dec_en);
        nrst = 1'b1;
    endtask : do_reset

    // One strobe cycle: pulse three edges after the rise, gone one edge later
    task automatic latch_check(input logic [`HBS_ADDR_W-1:0] a, input logic q, input logic w);
        i_host_pin_model.strobe_rise(a, q, w);
        edges(3);
        cmp_bit("latch_pulse", 1'b1, pulse);
        cmp_vec("latched_addr", {1'b0, a}, {1'b0, l_addr});
        cmp_bit("latched_qual", q, l_q);
        cmp_bit("decode_enable", ~q, dec_en);
        cmp_bit("access_is_write", w, is_wr);
        edges(1);
        cmp_bit("pulse_end", 1'b0, pulse);
    endtask : latch_check

    // Watchdog: whole run is about 107 cycles
    initial begin
        #200000;
        bad_count++;
        give_verdict();
    end

    initial begin
        nrst = 1'b0;
        @(posedge core_clk);
        #1;
        // Strap table: one reset per row
        foreach (rows[i]) begin
            do_reset(rows[i]);
            // Settle counter ends at the 5th edge after release
            edges(4);
            cmp_bit("early_valid", 1'b0, width_valid);
            edges(1);
            cmp_bit("width_valid", 1'b1, width_valid);
            if (rows[i].chkw) begin
                cmp_vec("bus_width", {14'h0000, rows[i].width}, {14'h0000, bus_width});
            end
            // Memory data path updates one edge after the strap capture
            edges(1);
            cmp_bit("mem_valid", rows[i].mem, mem_bit_valid);
            cmp_bit("mem_bit", rows[i].mem & rows[i].data, mem_bit);
        end
        // Memory data keeps following the data pin
        i_host_pin_model.set_straps(1'b1, 1'b0, 1'b0);
        edges(3);
        cmp_bit("mem_bit_low", 1'b0, mem_bit);
        // Strobe inside the settle window must not latch
        do_reset(rows[0]);
        i_host_pin_model.strobe_rise(15'h5555, 1'b0, 1'b1);
        edges(3);
        cmp_bit("early_pulse", 1'b0, pulse);
        cmp_bit("early_qual", 1'b1, l_q);
        cmp_vec("early_addr", 16'h0000, {1'b0, l_addr});
        edges(4);
        // Back-to-back strobes at the top address and two others
        latch_check(15'h7FFF, 1'b0, 1'b1);
        latch_check(15'h0001, 1'b1, 1'b0);
        latch_check(15'h2AAA, 1'b0, 1'b0);
        // Released bus must not disturb the held latch
        i_host_pin_model.release_addr();
        edges(4);
        cmp_vec("held_addr", 16'h2AAA, {1'b0, l_addr});
        // Power-down gates decode, wake restores it
        i_host_pin_model.set_sleep(1'b0);
        edges(3);
        cmp_bit("asleep", 1'b1, asleep);
        cmp_bit("sleep_decode", 1'b0, dec_en);
        i_host_pin_model.set_sleep(1'b1);
        edges(3);
        cmp_bit("awake", 1'b0, asleep);
        cmp_bit("wake_decode", 1'b1, dec_en);
        give_verdict();
    end
endmodule : host_bus_strap_and_strobe_tb_top

// file: verification/host_pin_model.sv
// Behavioural host CPU driving the strap, strobe and power-down pins.
// Assumes callers enter each task just after a rising edge of core_clk.
`timescale 1ns/1ps
`include "host_bus_strap_params.svh"
module host_pin_model (
    input  wire logic                   core_clk,
    output logic                        cfg_mem_present_strap,
    output logic                        cfg_mem_data_in,
    output logic                        bus32_strap,
    output logic                        sync_write_not_read,
    output logic                        addr_qualifier_n,
    output logic                        addr_latch_strobe_n,
    output logic      [`HBS_ADDR_W-1:0] host_addr,
    output logic                        chip_sleep_n
);
    // Idle levels: qualifier and sleep pins rest high, strobe idles high
    initial begin
        {cfg_mem_present_strap, cfg_mem_data_in, bus32_strap} = 3'h0;
        sync_write_not_read = 1'b0;
        addr_qualifier_n    = 1'b1;
        addr_latch_strobe_n = 1'b1;
        host_addr           = '0;
        chip_sleep_n        = 1'b1;
    end

    // Board straps, set while reset is held and once after it to move the data pin
    task automatic set_straps(input logic mem, input logic data, input logic b32);
        cfg_mem_present_strap = mem;
        cfg_mem_data_in       = data;
        bus32_strap           = b32;
    endtask : set_straps

    // Strobe low two clocks with address held, then rise; address stays put
    task automatic strobe_rise(input logic [`HBS_ADDR_W-1:0] a, input logic q, input logic w);
        host_addr           = a;
        addr_qualifier_n    = q;
        sync_write_not_read = w;
        addr_latch_strobe_n = 1'b0;
        repeat (2) @(posedge core_clk);
        #1 addr_latch_strobe_n = 1'b1;
    endtask : strobe_rise

    // Address bus has no pull, so a released bus shows a changed value
    task automatic release_addr();
        host_addr = ~host_addr;
    endtask : release_addr

    // Power-down pin level
    task automatic set_sleep(input logic s);
        chip_sleep_n = s;
    endtask : set_sleep
endmodule : host_pin_model
